// >>> hdl/refclk_pkg.sv
// constants for the reference input controls and their bus map
// assumes a 32-bit AHB-Lite bus, one aligned word per register
package refclk_pkg;
    // register indices as printed, byte address is four times the index
    localparam logic [7:0] IDX_INPUT_CLOCK_CONTROL = 8'h33;
    localparam logic [7:0] IDX_REFERENCE_DIVIDER = 8'h34;
    localparam logic [7:0] IDX_REF_STATUS = 8'h35;
    localparam int ADDR_W = 10;
    localparam logic [9:0] ADDR_INPUT_CLOCK_CONTROL =
        {IDX_INPUT_CLOCK_CONTROL, 2'b00};
    localparam logic [9:0] ADDR_REFERENCE_DIVIDER =
        {IDX_REFERENCE_DIVIDER, 2'b00};
    localparam logic [9:0] ADDR_REF_STATUS = {IDX_REF_STATUS, 2'b00};
    // input_clock_control fields
    localparam int BIT_MUX_BYPASS = 7;
    localparam int BIT_KEEP_SEC_ON = 2;
    localparam int BIT_SEC_GAIN = 1;
    localparam int BIT_PRI_GAIN = 0;
    localparam logic [7:0] RST_INPUT_CLOCK_CONTROL = 8'h03;
    // reference_divider field [2:0], upper bits read zero
    localparam int RDIV_W = 3;
    localparam logic [2:0] RST_REF_DIVIDER = 3'h0;
    // status fields
    localparam int BIT_STAT_SEC_SEL = 0;
    localparam int BIT_STAT_SEC_BUF = 1;
    localparam int BIT_STAT_SWITCHING = 2;
    // reference selection modes
    localparam logic [1:0] SEL_AUTO = 2'h0;
    localparam logic [1:0] SEL_PIN = 2'h1;
    localparam logic [1:0] SEL_PRIMARY = 2'h2;
    localparam logic [1:0] SEL_SECONDARY = 2'h3;
    // pin codes in pin mode
    localparam logic [1:0] PIN_PRIMARY = 2'h0;
    localparam logic [1:0] PIN_SECONDARY = 2'h1;
    // glitch-free mux quiet time
    localparam int CLK_PERIOD_NS = 50;
    localparam int GUARD_NS = 100;
    localparam int GUARD_CYCLES_I =
        (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] GUARD_CYCLES = GUARD_CYCLES_I[2:0];
    // ahb
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [2:0] {
        ST_PRI = 3'b001,
        ST_SEC = 3'b010,
        ST_HOLD = 3'b100
    } ref_state_e;
endpackage

// >>> hdl/ref_divider.sv
// reference pre-divider: one output pulse per (code+1) input edges
// assumes edge_in is a one-cycle pulse per reference rising edge
`timescale 1ns/1ps
module ref_divider (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // divider
    input wire logic edge_in,
    input wire logic [refclk_pkg::RDIV_W-1:0] code,
    output logic pulse_out
);
    import refclk_pkg::*;

    logic [RDIV_W-1:0] cnt_reg;

    // code 0 passes every edge, code n divides by n+1
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= '0;
            pulse_out <= 1'b0;
        end else if (edge_in && cnt_reg >= code) begin
            cnt_reg <= '0;
            pulse_out <= 1'b1;
        end else if (edge_in) begin
            cnt_reg <= cnt_reg + 3'h1;
            pulse_out <= 1'b0;
        end else begin
            pulse_out <= 1'b0;
        end
    end
endmodule

// >>> hdl/pll_input_clock_controls.sv
// reference input controls: bus registers, reference select, mux, divider
// assumes reference inputs are sampled levels synchronous to hclk
//
// Notes on behaviour
// - bypass bit 7 set: paths skip the glitch-free mux; clear keeps it
// - keep-secondary-on clear: secondary buffer off after return to primary
// - keep-secondary-on set: secondary buffer stays on after return
// - bit 1 sets secondary buffer gain, 0 minimum, 1 maximum, resets 1
// - bit 0 sets primary buffer gain, 0 minimum, 1 maximum, resets 1
// - divider code 0 bypasses, 1 divides by two, 7 by eight, resets 0
// - automatic mode prefers primary, uses secondary only if primary unusable
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ps
module pll_input_clock_controls (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // reference selection inputs
    input wire logic [1:0] pll_reference_select,
    input wire logic [1:0] ref_pin_code,
    input wire logic pri_usable,
    input wire logic sec_usable,
    input wire logic pri_ref_in,
    input wire logic sec_ref_in,
    // analog controls and reference out
    output logic primary_buffer_gain,
    output logic secondary_buffer_gain,
    output logic sec_buffer_enable,
    output logic ref_mux_bypass,
    output logic pll_ref_out,
    output logic pll_ref_div_pulse
);
    import refclk_pkg::*;

    logic [7:0] ctl_reg;
    logic [7:0] ctl_next;
    logic [RDIV_W-1:0] rdiv_reg;
    logic [RDIV_W-1:0] rdiv_next;
    logic wr_pend_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic addr_ok;
    logic rd_req;
    logic [31:0] rd_val;
    ref_state_e state_reg;
    logic target_sec_reg;
    logic [2:0] guard_reg;
    logic want_sec;
    logic mux_val;
    logic ref_q_reg;
    logic ref_edge;
    logic keep_sec_on;

    assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
    assign rd_req = addr_ok && !hwrite;
    assign keep_sec_on = ctl_reg[BIT_KEEP_SEC_ON];

    // write data lands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr[ADDR_W-1:0];
        end
    end

    always_comb begin
        ctl_next = ctl_reg;
        rdiv_next = rdiv_reg;
        if (wr_pend_reg && wr_addr_reg == ADDR_INPUT_CLOCK_CONTROL) begin
            ctl_next = hwdata[7:0];
        end
        if (wr_pend_reg && wr_addr_reg == ADDR_REFERENCE_DIVIDER) begin
            rdiv_next = hwdata[RDIV_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_reg <= RST_INPUT_CLOCK_CONTROL;
            rdiv_reg <= RST_REF_DIVIDER;
        end else begin
            ctl_reg <= ctl_next;
            rdiv_reg <= rdiv_next;
        end
    end

    // reads see a write still in its data phase
    always_comb begin
        rd_val = 32'h0;
        case (haddr[ADDR_W-1:0])
            ADDR_INPUT_CLOCK_CONTROL: rd_val = {24'h0, ctl_next};
            ADDR_REFERENCE_DIVIDER: rd_val = {29'h0, rdiv_next};
            ADDR_REF_STATUS: begin
                rd_val[BIT_STAT_SEC_SEL] = state_reg == ST_SEC;
                rd_val[BIT_STAT_SEC_BUF] = sec_buffer_enable;
                rd_val[BIT_STAT_SWITCHING] = state_reg == ST_HOLD;
            end
            default: rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= rd_req ? rd_val : 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // control outputs follow the register with one flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            primary_buffer_gain <= RST_INPUT_CLOCK_CONTROL[BIT_PRI_GAIN];
            secondary_buffer_gain <= RST_INPUT_CLOCK_CONTROL[BIT_SEC_GAIN];
            ref_mux_bypass <= RST_INPUT_CLOCK_CONTROL[BIT_MUX_BYPASS];
        end else begin
            primary_buffer_gain <= ctl_reg[BIT_PRI_GAIN];
            secondary_buffer_gain <= ctl_reg[BIT_SEC_GAIN];
            ref_mux_bypass <= ctl_reg[BIT_MUX_BYPASS];
        end
    end

    // desired reference
    always_comb begin
        case (pll_reference_select)
            SEL_AUTO: want_sec = !pri_usable && sec_usable;
            SEL_PIN: begin
                if (ref_pin_code == PIN_PRIMARY) begin
                    want_sec = 1'b0;
                end else if (ref_pin_code == PIN_SECONDARY) begin
                    want_sec = 1'b1;
                end else begin
                    want_sec = !pri_usable && sec_usable;
                end
            end
            SEL_PRIMARY: want_sec = 1'b0;
            SEL_SECONDARY: want_sec = 1'b1;
            default: want_sec = 1'b0;
        endcase
    end

    // selection state; the mux quiets the output while switching
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_PRI;
            target_sec_reg <= 1'b0;
            guard_reg <= 3'h0;
        end else begin
            case (state_reg)
                ST_PRI: begin
                    if (want_sec && ctl_reg[BIT_MUX_BYPASS]) begin
                        state_reg <= ST_SEC;
                    end else if (want_sec) begin
                        state_reg <= ST_HOLD;
                        target_sec_reg <= 1'b1;
                        guard_reg <= GUARD_CYCLES;
                    end
                end
                ST_SEC: begin
                    if (!want_sec && ctl_reg[BIT_MUX_BYPASS]) begin
                        state_reg <= ST_PRI;
                    end else if (!want_sec) begin
                        state_reg <= ST_HOLD;
                        target_sec_reg <= 1'b0;
                        guard_reg <= GUARD_CYCLES;
                    end
                end
                ST_HOLD: begin
                    if (guard_reg <= 3'h1) begin
                        state_reg <= target_sec_reg ? ST_SEC : ST_PRI;
                        guard_reg <= 3'h0;
                    end else begin
                        guard_reg <= guard_reg - 3'h1;
                    end
                end
                default: state_reg <= ST_PRI;
            endcase
        end
    end

    // secondary crystal buffer: on while used, off on return unless kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sec_buffer_enable <= 1'b1;
        end else if (want_sec) begin
            sec_buffer_enable <= 1'b1;
        end else if (state_reg == ST_SEC || state_reg == ST_HOLD) begin
            sec_buffer_enable <= keep_sec_on;
        end
    end

    always_comb begin
        case (state_reg)
            ST_PRI: mux_val = pri_ref_in;
            ST_SEC: mux_val = sec_ref_in;
            ST_HOLD: mux_val = 1'b0;
            default: mux_val = 1'b0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pll_ref_out <= 1'b0;
            ref_q_reg <= 1'b0;
        end else begin
            pll_ref_out <= mux_val;
            ref_q_reg <= pll_ref_out;
        end
    end

    assign ref_edge = pll_ref_out && !ref_q_reg;

    ref_divider u_ref_divider (
        .hclk(hclk),
        .hresetn(hresetn),
        .edge_in(ref_edge),
        .code(rdiv_reg),
        .pulse_out(pll_ref_div_pulse)
    );

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_bypass_direct_switch: assert property (
        state_reg == ST_PRI && want_sec && ctl_reg[BIT_MUX_BYPASS]
        |=> state_reg == ST_SEC)
        else $error("bypassed mux did not switch directly");
    a_mux_hold_used: assert property (
        state_reg == ST_PRI && want_sec && !ctl_reg[BIT_MUX_BYPASS]
        |=> state_reg == ST_HOLD ##1 state_reg == ST_HOLD ##1 !pll_ref_out)
        else $error("mux did not quiet the output while switching");
    a_sec_buf_off: assert property (
        state_reg == ST_SEC && !want_sec && !keep_sec_on
        |=> !sec_buffer_enable)
        else $error("secondary buffer left on after return");
    a_sec_buf_kept: assert property (
        keep_sec_on && sec_buffer_enable |=> sec_buffer_enable)
        else $error("secondary buffer dropped while kept on");
    a_sec_gain_out: assert property (
        ##1 secondary_buffer_gain == $past(ctl_reg[BIT_SEC_GAIN]))
        else $error("secondary gain does not follow register");
    a_pri_gain_out: assert property (
        ##1 primary_buffer_gain == $past(ctl_reg[BIT_PRI_GAIN]))
        else $error("primary gain does not follow register");
    a_div_bypass: assert property (
        rdiv_reg == 3'h0 && $stable(rdiv_reg) && ref_edge
        |=> pll_ref_div_pulse)
        else $error("divider bypass missed an edge");
    a_div_spacing: assert property (
        pll_ref_div_pulse && rdiv_reg != 3'h0 && $stable(rdiv_reg)
        |=> !pll_ref_div_pulse ##1 !pll_ref_div_pulse)
        else $error("divided pulses too close");
    a_auto_prefers_pri: assert property (
        pll_reference_select == SEL_AUTO && pri_usable |-> !want_sec)
        else $error("automatic mode left the usable primary");

    // register writes and register-driven outputs
    a_ctl_write_lands: assert property (
        wr_pend_reg && wr_addr_reg == ADDR_INPUT_CLOCK_CONTROL
        |=> ctl_reg == $past(hwdata[7:0]))
        else $error("control write did not land");
    a_rdiv_write_lands: assert property (
        wr_pend_reg && wr_addr_reg == ADDR_REFERENCE_DIVIDER
        |=> rdiv_reg == $past(hwdata[RDIV_W-1:0]))
        else $error("divider write did not land");
    a_bypass_out: assert property (
        ##1 ref_mux_bypass == $past(ctl_reg[BIT_MUX_BYPASS]))
        else $error("bypass output does not follow register");

    // reference switching
    a_hold_length: assert property (
        $rose(state_reg == ST_HOLD)
        |-> (state_reg == ST_HOLD) [*2] ##1 state_reg != ST_HOLD)
        else $error("mux quiet time has the wrong length");
    a_auto_returns_pri: assert property (
        (pll_reference_select == SEL_AUTO && pri_usable) [*7]
        |-> state_reg == ST_PRI)
        else $error("automatic mode did not return to primary");

    // coverage of the main scenarios
    c_switch_to_sec: cover property (state_reg == ST_HOLD ##[1:3]
        state_reg == ST_SEC);
    c_return_kept: cover property (state_reg == ST_SEC && !want_sec &&
        keep_sec_on);
    c_div_eight: cover property (rdiv_reg == 3'h7 && pll_ref_div_pulse);
    c_pin_secondary: cover property (pll_reference_select == SEL_PIN &&
        state_reg == ST_SEC);
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the reference input controls
// assumes a zero-wait ahb-lite slave and sampled reference levels
`timescale 1ns/1ps
module tb_top;
    import refclk_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [1:0] sel_mode = SEL_AUTO;
    logic [1:0] pin_code = PIN_PRIMARY;
    logic pri_ok = 1'b1;
    logic sec_ok = 1'b1;
    logic pri_in = 1'b0;
    logic sec_in = 1'b0;
    logic refs_high = 1'b0;
    logic [2:0] tick = 3'h0;
    logic pgain, sgain, sbuf, bypass, ref_out, dpulse;
    int err_total = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    int n;
    int gap_exp [6] = '{4, 8, 4, 8, 4, 4};
    logic [1:0] mode_tab [6] = '{SEL_PRIMARY, SEL_SECONDARY, SEL_PIN,
        SEL_PIN, SEL_PIN, SEL_AUTO};
    logic [1:0] pin_tab [6] = '{2'h0, 2'h0, PIN_PRIMARY, PIN_SECONDARY,
        2'h2, 2'h0};

    always #25 hclk = ~hclk;

    // primary rises every 4 cycles, secondary every 8
    always @(posedge hclk) begin
        tick <= tick + 3'h1;
        pri_in <= refs_high | tick[1];
        sec_in <= refs_high | tick[2];
    end

    pll_input_clock_controls u_pll_input_clock_controls (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pll_reference_select(sel_mode),
        .ref_pin_code(pin_code),
        .pri_usable(pri_ok), .sec_usable(sec_ok), .pri_ref_in(pri_in),
        .sec_ref_in(sec_in), .primary_buffer_gain(pgain),
        .secondary_buffer_gain(sgain), .sec_buffer_enable(sbuf),
        .ref_mux_bypass(bypass), .pll_ref_out(ref_out),
        .pll_ref_div_pulse(dpulse));

    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_ready();
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            @(posedge hclk);
        end
    endtask

    // one single-word transfer, address phase then data phase
    task automatic xfer(logic wr, logic [9:0] a, logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? wd : 32'h0;
        wait_ready();
        rd = hrdata;
    endtask

    // cycles until the next divider pulse
    task automatic wait_pulse();
        n = 0;
        @(posedge hclk);
        while (dpulse !== 1'b1 && n < 100) begin
            n++;
            @(posedge hclk);
        end
    endtask

    task automatic gap_check(int exp);
        wait_pulse();
        wait_pulse();
        chk("divider gap", exp, n + 1);
    endtask

    task automatic zero_count(int exp);
        int z;
        z = 0;
        @(posedge hclk);
        sel_mode <= SEL_SECONDARY;
        repeat (10) begin
            @(posedge hclk);
            if (ref_out !== 1'b1) z++;
        end
        chk("hold cycles", exp, z);
    endtask

    initial begin
        #1000000;
        err_total++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, ADDR_INPUT_CLOCK_CONTROL, 32'h0);
        chk("ctl reset", 32'h3, rd);
        chk("hresp okay", 32'h0, hresp);
        chk("gains reset", 32'h3, {pgain, sgain});
        chk("bypass reset", 32'h0, bypass);
        xfer(1'b0, ADDR_REFERENCE_DIVIDER, 32'h0);
        chk("rdiv reset", 32'h0, rd);
        xfer(1'b1, ADDR_INPUT_CLOCK_CONTROL, 32'hFFFFFFFC);
        xfer(1'b0, ADDR_INPUT_CLOCK_CONTROL, 32'h0);
        chk("ctl readback", 32'hFC, rd);
        chk("gains min", 32'h0, {pgain, sgain});
        chk("bypass set", 32'h1, bypass);
        xfer(1'b1, ADDR_INPUT_CLOCK_CONTROL, 32'h1);
        repeat (2) @(posedge hclk);
        chk("pri max sec min", 32'h1, {sgain, pgain});
        xfer(1'b1, ADDR_INPUT_CLOCK_CONTROL, 32'h2);
        repeat (2) @(posedge hclk);
        chk("sec max pri min", 32'h2, {sgain, pgain});
        xfer(1'b1, ADDR_REFERENCE_DIVIDER, 32'hFFFFFFFF);
        xfer(1'b0, ADDR_REFERENCE_DIVIDER, 32'h0);
        chk("rdiv upper zero", 32'h7, rd);
        xfer(1'b1, 10'h000, 32'hFFFFFFFF);
        xfer(1'b0, 10'h000, 32'h0);
        chk("unmapped read", 32'h0, rd);
        for (int c = 0; c < 8; c++) begin
            xfer(1'b1, ADDR_REFERENCE_DIVIDER, c);
            gap_check(4 * (c + 1));
        end
        xfer(1'b1, ADDR_REFERENCE_DIVIDER, 32'h0);
        for (int m = 0; m < 6; m++) begin
            sel_mode <= mode_tab[m];
            pin_code <= pin_tab[m];
            repeat (12) @(posedge hclk);
            gap_check(gap_exp[m]);
        end
        // auto mode: primary lost, then back
        pri_ok <= 1'b0;
        repeat (12) @(posedge hclk);
        gap_check(8);
        chk("sec buffer on", 32'h1, sbuf);
        xfer(1'b0, ADDR_REF_STATUS, 32'h0);
        chk("status secondary", 32'h1, rd[BIT_STAT_SEC_SEL]);
        chk("status buffer", 32'h1, rd[BIT_STAT_SEC_BUF]);
        pri_ok <= 1'b1;
        repeat (12) @(posedge hclk);
        gap_check(4);
        chk("sec buffer off", 32'h0, sbuf);
        xfer(1'b1, ADDR_INPUT_CLOCK_CONTROL, 32'h7);
        pri_ok <= 1'b0;
        repeat (12) @(posedge hclk);
        pri_ok <= 1'b1;
        repeat (12) @(posedge hclk);
        chk("sec buffer kept", 32'h1, sbuf);
        // auto mode with neither input usable stays on primary
        pri_ok <= 1'b0;
        sec_ok <= 1'b0;
        repeat (12) @(posedge hclk);
        gap_check(4);
        pri_ok <= 1'b1;
        sec_ok <= 1'b1;
        // mux quiet time with both references high
        refs_high <= 1'b1;
        sel_mode <= SEL_PRIMARY;
        repeat (12) @(posedge hclk);
        zero_count(2);
        sel_mode <= SEL_PRIMARY;
        xfer(1'b1, ADDR_INPUT_CLOCK_CONTROL, 32'h83);
        repeat (12) @(posedge hclk);
        zero_count(0);
        // reset in mid-run brings back the defaults
        xfer(1'b1, ADDR_REFERENCE_DIVIDER, 32'h5);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        chk("sec buffer reset", 32'h1, sbuf);
        xfer(1'b0, ADDR_INPUT_CLOCK_CONTROL, 32'h0);
        chk("ctl after reset", 32'h3, rd);
        chk("bypass after reset", 32'h0, bypass);
        xfer(1'b0, ADDR_REFERENCE_DIVIDER, 32'h0);
        chk("rdiv after reset", 32'h0, rd);
        conclude();
    end
endmodule
